// file: power_mode_map.vh
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define POWER_CONTROL_ADDR   8'h87
`define POWER_CONTROL_RESET  8'h00
`define IDLE_SELECT_BIT      0
`define STOP_SELECT_BIT      1

// ----------------------------------------------------------------------
// Timing and resume address
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS        10
`define LOST_CLOCK_TIME_US   100
`define LOST_CLOCK_CYCLES    ((`LOST_CLOCK_TIME_US * 1000) / `CLK_PERIOD_NS)
`define RESUME_ADDRESS       16'h0000

`endif

// file: idle_wake_detect.v
`timescale 1ns/1ps
`include "power_mode_map.vh"

module idle_wake_detect
(
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Interrupt sources
    input  wire [7:0] irq_pending,
    input  wire [7:0] irq_enable,
    input  wire       global_irq_enable,
    // Wake request
    output wire       wake
);

    // ------------------------------------------------------------------
    // Any enabled interrupt ends Idle while global_irq_enable is set
    // ------------------------------------------------------------------
    assign wake = global_irq_enable & (|(irq_pending & irq_enable));

endmodule

// file: watchdog_counter.v
`timescale 1ns/1ps
`include "power_mode_map.vh"

module watchdog_counter
#(
    parameter WIDTH = 21
)
(
    // Clock and reset
    input  wire clk,
    input  wire reset,
    // Control
    input  wire enable,
    input  wire restart,
    input  wire halted,
    // Overflow
    output reg  overflow
);

    reg [WIDTH-1:0] count_reg;

    // ------------------------------------------------------------------
    // Counter, frozen only while the oscillator is stopped
    // ------------------------------------------------------------------
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            count_reg <= {WIDTH{1'b0}};
            overflow  <= 1'b0;
        end
        else
        begin
            overflow <= 1'b0;
            if (restart || !enable)
                count_reg <= {WIDTH{1'b0}};
            else if (!halted)
            begin
                count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
                if (&count_reg)
                    overflow <= 1'b1;
            end
        end
    end

endmodule

// file: cpu_power_mode_control.v
`timescale 1ns/1ps
`include "power_mode_map.vh"

module cpu_power_mode_control
#(
    parameter WATCHDOG_WIDTH = 21,
    parameter LOST_COUNT = `LOST_CLOCK_CYCLES
)
(
    // Clock and resets
    input  wire        clk,
    input  wire        reset,
    input  wire        ext_reset,
    // Special function register access
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_write,
    output reg  [7:0]  sfr_rdata,
    // Core handshake
    input  wire        instr_done,
    input  wire        core_clock_present,
    // Interrupts
    input  wire [7:0]  irq_pending,
    input  wire [7:0]  irq_enable,
    input  wire        global_irq_enable,
    // Watchdog and lost-clock monitor control
    input  wire        watchdog_enable,
    input  wire        watchdog_restart,
    input  wire        lost_clock_monitor_enable,
    // Power outputs
    output wire        core_halt,
    output wire        irq_block,
    output wire        timers_halt,
    output wire        osc_enable,
    output wire        idle_wake,
    output reg         internal_reset,
    output wire [15:0] reset_vector
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_IDLE = 3'b010;
    localparam [2:0] ST_STOP = 3'b100;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg         idle_sel_reg;
    reg         idle_sel_next;
    reg         stop_req_reg;
    reg         stop_req_next;
    reg  [31:0] lost_cnt_reg;
    wire        wake;
    wire        watchdog_overflow;
    wire        reg_hit;

    assign reg_hit = sfr_write && (sfr_addr == `POWER_CONTROL_ADDR);

    // ------------------------------------------------------------------
    // Leaf modules
    // ------------------------------------------------------------------
    idle_wake_detect u_wake
    (
        .clk               (clk),
        .reset             (reset),
        .irq_pending       (irq_pending),
        .irq_enable        (irq_enable),
        .global_irq_enable (global_irq_enable),
        .wake              (wake)
    );

    watchdog_counter #(.WIDTH(WATCHDOG_WIDTH)) u_watchdog
    (
        .clk      (clk),
        .reset    (reset),
        .enable   (watchdog_enable),
        .restart  (watchdog_restart),
        .halted   (state_reg == ST_STOP),
        .overflow (watchdog_overflow)
    );

    // ------------------------------------------------------------------
    // Mode select bits and state
    // ------------------------------------------------------------------
    always @*
    begin
        idle_sel_next = idle_sel_reg;
        stop_req_next = stop_req_reg;
        state_next    = state_reg;
        // Writing zero never clears a pending select bit.
        if (reg_hit && sfr_wdata[`STOP_SELECT_BIT])
            stop_req_next = 1'b1;
        else if (reg_hit && sfr_wdata[`IDLE_SELECT_BIT])
            idle_sel_next = 1'b1;
        case (state_reg)
            ST_RUN:
            begin
                // Entry waits for the writing instruction to finish.
                if (instr_done && stop_req_next)
                begin
                    state_next    = ST_STOP;
                    stop_req_next = 1'b0;
                    idle_sel_next = 1'b0;
                end
                else if (instr_done && idle_sel_next)
                    state_next = ST_IDLE;
            end
            ST_IDLE:
            begin
                // Nothing but an enabled interrupt leaves Idle here.
                if (wake)
                begin
                    state_next    = ST_RUN;
                    idle_sel_next = 1'b0;
                end
            end
            ST_STOP:
                state_next = ST_STOP;
            default:
                state_next = ST_RUN;
        endcase
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg    <= ST_RUN;
            idle_sel_reg <= 1'b0;
            stop_req_reg <= 1'b0;
        end
        else if (internal_reset)
        begin
            // Any internal reset ends Idle or Stop and restarts the core.
            state_reg    <= ST_RUN;
            idle_sel_reg <= 1'b0;
            stop_req_reg <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            idle_sel_reg <= idle_sel_next;
            stop_req_reg <= stop_req_next;
        end
    end

    // ------------------------------------------------------------------
    // Lost-clock monitor: counts cycles without a core clock tick.
    // ------------------------------------------------------------------
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            lost_cnt_reg <= 32'h0000_0000;
        else if (!lost_clock_monitor_enable || core_clock_present
                 || internal_reset)
            lost_cnt_reg <= 32'h0000_0000;
        else if (lost_cnt_reg < LOST_COUNT)
            lost_cnt_reg <= lost_cnt_reg + 32'h0000_0001;
    end

    // ------------------------------------------------------------------
    // Internal reset: one-cycle pulse from ext_reset, the watchdog or the lost-clock monitor.
    // ------------------------------------------------------------------
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            internal_reset <= 1'b0;
        else
            internal_reset <= !internal_reset
                && (ext_reset
                    || watchdog_overflow
                    || (lost_clock_monitor_enable
                        && lost_cnt_reg >= LOST_COUNT));
    end

    // ------------------------------------------------------------------
    // Read data: only the idle bit reads back.
    // ------------------------------------------------------------------
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            sfr_rdata <= `POWER_CONTROL_RESET;
        else if (sfr_addr == `POWER_CONTROL_ADDR)
            sfr_rdata <= {7'b000_0000, idle_sel_reg};
        else
            sfr_rdata <= 8'h00;
    end

    // ------------------------------------------------------------------
    // Power outputs. Idle only gates the core, so state is kept; the
    // return address is the core's own stack, untouched here.
    // ------------------------------------------------------------------
    assign core_halt    = (state_reg != ST_RUN);
    assign irq_block    = (state_reg == ST_STOP);
    assign timers_halt  = (state_reg == ST_STOP);
    assign osc_enable   = (state_reg != ST_STOP);
    assign idle_wake    = (state_reg == ST_IDLE) && wake;
    assign reset_vector = `RESUME_ADDRESS;

endmodule

// file: power_mode_monitor.sv
`timescale 1ns/1ps
module power_mode_monitor
(
    // Clock and reset
    input wire       clk,
    input wire       reset,
    // Register access
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire       sfr_write,
    input wire       instr_done,
    // Read data and power outputs
    input wire [7:0] sfr_rdata,
    input wire       core_halt,
    input wire       osc_enable,
    input wire       irq_block,
    input wire       timers_halt,
    input wire       idle_wake,
    input wire       internal_reset
);
    // --------
    // Checks
    // --------
    wire go = sfr_write && sfr_addr == 8'h87 && instr_done;
    wire idle = core_halt && osc_enable;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_idle;
        go && sfr_wdata[1:0] == 2'b01 && !core_halt |=> idle && !irq_block;
    endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_stop;
        go && sfr_wdata[1] |=> !osc_enable && irq_block && timers_halt;
    endproperty
    a_stop: assert property (p_stop) else $error("stop");
    property p_hold;
        idle && !idle_wake && !internal_reset |=> core_halt || internal_reset;
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_wake;
        idle_wake |-> idle ##1 !core_halt;
    endproperty
    a_wake: assert property (p_wake) else $error("wake");
    property p_park;
        !osc_enable && !internal_reset |=> !osc_enable || internal_reset;
    endproperty
    a_park: assert property (p_park) else $error("park");
    property p_rd;
        sfr_rdata[7:1] == 7'h00 &&
        ($past(sfr_addr) == 8'h87 || sfr_rdata == 8'h00);
    endproperty
    a_rd: assert property (p_rd) else $error("read");
    property p_pulse;
        internal_reset |=> !internal_reset;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse");
    property p_fresh;
        internal_reset |=> !core_halt;
    endproperty
    a_fresh: assert property (p_fresh) else $error("fresh");
    c_wake: cover property (idle_wake);
    c_stop: cover property (go && sfr_wdata[1]);
    c_rst: cover property (internal_reset && core_halt);
endmodule

bind cpu_power_mode_control power_mode_monitor power_mode_monitor_inst
(
    .clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_write(sfr_write), .instr_done(instr_done), .sfr_rdata(sfr_rdata),
    .core_halt(core_halt), .osc_enable(osc_enable), .irq_block(irq_block),
    .timers_halt(timers_halt), .idle_wake(idle_wake),
    .internal_reset(internal_reset)
);

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        ext_reset = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_write = 1'b0;
    logic        instr_done = 1'b0;
    logic        core_clock_present = 1'b1;
    logic [7:0]  irq_pending = 8'h00;
    logic [7:0]  irq_enable = 8'h00;
    logic        global_irq_enable = 1'b0;
    logic        watchdog_enable = 1'b0;
    logic        watchdog_restart = 1'b0;
    logic        lost_clock_monitor_enable = 1'b0;
    logic [7:0]  sfr_rdata;
    logic [15:0] reset_vector;
    logic        core_halt, irq_block, timers_halt, osc_enable;
    logic        idle_wake, internal_reset;
    int          error_cnt = 0;
    int          checked = 0;

    always #5 clk = ~clk;

    // Short counts keep the watchdog and lost-clock waits to tens of cycles.
    cpu_power_mode_control #(.WATCHDOG_WIDTH(6), .LOST_COUNT(20))
    cpu_power_mode_control_inst
    (
        .clk(clk), .reset(reset), .ext_reset(ext_reset),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
        .sfr_rdata(sfr_rdata), .instr_done(instr_done),
        .core_clock_present(core_clock_present), .irq_pending(irq_pending),
        .irq_enable(irq_enable), .global_irq_enable(global_irq_enable),
        .watchdog_enable(watchdog_enable),
        .watchdog_restart(watchdog_restart),
        .lost_clock_monitor_enable(lost_clock_monitor_enable),
        .core_halt(core_halt), .irq_block(irq_block),
        .timers_halt(timers_halt), .osc_enable(osc_enable),
        .idle_wake(idle_wake), .internal_reset(internal_reset),
        .reset_vector(reset_vector)
    );

    task report_and_stop;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // State is {core_halt, osc_enable, irq_block, timers_halt}.
    task st(input logic [3:0] e);
        #1;
        cmp({4'h0, core_halt, osc_enable, irq_block, timers_halt}, {4'h0, e});
    endtask

    task wr(input logic [7:0] d, input logic done);
        @(posedge clk);
        sfr_addr <= 8'h87;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        instr_done <= done;
        @(posedge clk);
        sfr_write <= 1'b0;
        instr_done <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        @(posedge clk);
        #1;
        cmp(sfr_rdata, e);
    endtask

    task wait_reset(input int n);
        int i;
        for (i = 0; i < n && internal_reset !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        cmp({7'h00, internal_reset}, 8'h01);
    endtask

    initial
    begin
        #20000;
        error_cnt++;
        report_and_stop;
    end

    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(8'h87, 8'h00);
        rd(8'h3c, 8'h00);
        wr(8'h00, 1'b1);
        st(4'b0100);
        // The request must wait for the end of the writing instruction.
        wr(8'h01, 1'b0);
        st(4'b0100);
        wr(8'h00, 1'b1);
        st(4'b1100);
        rd(8'h87, 8'h01);
        @(posedge clk);
        irq_pending <= 8'h01;
        irq_enable <= 8'h02;
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge clk);
        st(4'b1100);
        @(posedge clk);
        irq_enable <= 8'h01;
        global_irq_enable <= 1'b0;
        repeat (3) @(posedge clk);
        st(4'b1100);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        repeat (2) @(posedge clk);
        st(4'b0100);
        rd(8'h87, 8'h00);
        @(posedge clk);
        irq_pending <= 8'h00;
        wr(8'h01, 1'b1);
        st(4'b1100);
        @(posedge clk);
        watchdog_enable <= 1'b1;
        wait_reset(200);
        @(posedge clk);
        watchdog_enable <= 1'b0;
        st(4'b0100);
        wr(8'h03, 1'b1);
        st(4'b1011);
        rd(8'h87, 8'h00);
        @(posedge clk);
        irq_pending <= 8'h01;
        repeat (3) @(posedge clk);
        st(4'b1011);
        @(posedge clk);
        ext_reset <= 1'b1;
        wait_reset(5);
        @(posedge clk);
        ext_reset <= 1'b0;
        irq_pending <= 8'h00;
        st(4'b0100);
        cmp(reset_vector[7:0], 8'h00);
        cmp(reset_vector[15:8], 8'h00);
        @(posedge clk);
        lost_clock_monitor_enable <= 1'b1;
        wr(8'h02, 1'b1);
        st(4'b1011);
        @(posedge clk);
        core_clock_present <= 1'b0;
        wait_reset(40);
        @(posedge clk);
        core_clock_present <= 1'b1;
        lost_clock_monitor_enable <= 1'b0;
        st(4'b0100);
        report_and_stop;
    end
endmodule
